// [logic/pslq_pkg.sv]
// constants for the status lamp and mii nibble qualify block
// assumes a 100 MHz core clock and a separate mii link clock
package pslq_pkg;
  localparam int          NIB_W           = 4;
  localparam int          FIFO_DEPTH      = 16;
  localparam int          LAMP_MODE_W     = 2;
  localparam logic [1:0]  LAMP_SPEED      = 2'h0;
  localparam logic [1:0]  LAMP_ACT        = 2'h1;
  localparam logic [4:0]  CTRL_REG_ADDR   = 5'h1F;
  localparam int          LAMP_MODE_LSB   = 4;
  localparam logic [4:0]  BASIC_CTRL_ADDR = 5'h00;
  localparam int          SPEED_SEL_BIT   = 13;
  localparam logic        LAMP_ON         = 1'b0;
  localparam logic        LAMP_OFF        = 1'b1;
  localparam int          MCLK_HZ         = 100_000_000;
  localparam int          BLINK_MS        = 40;
  localparam int          BLINK_CYC       = MCLK_HZ / 1000 * BLINK_MS;
  localparam logic [1:0]  STRAP_SETTLE    = 2'h2;
  typedef enum logic {ST_STRAP, ST_RUN} pslq_strap_type;
endpackage

// [logic/pslq_top.sv]
// status lamp drive, strap capture and mii nibble qualify with dual-clock fifos
// assumes lnk_clk is the mii clock the device supplies; core logic runs on mclk

module pslq_afifo #(
  parameter int W     = 4,
  parameter int DEPTH = 16
) (
  input  wire logic         wclk,
  input  wire logic         wrstn,
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_data,
  output logic              wr_ready,
  input  wire logic         rclk,
  input  wire logic         rrstn,
  output logic              rd_valid,
  output logic [W-1:0]      rd_data,
  input  wire logic         rd_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_q, wgray_q, wq1_q, wq2_q;
  logic [AW:0]  rbin_q, rgray_q, rq1_q, rq2_q;
  logic         wready_q, rvalid_q;

  wire         wpush   = wr_valid & wready_q;
  wire [AW:0]  wbin_d  = wbin_q + (AW+1)'(wpush);
  wire [AW:0]  wgray_d = (wbin_d >> 1) ^ wbin_d;
  wire         full_d  = wgray_d == {~wq2_q[AW:AW-1], wq2_q[AW-2:0]};
  wire         rpop    = rd_ready & rvalid_q;
  wire [AW:0]  rbin_d  = rbin_q + (AW+1)'(rpop);
  wire [AW:0]  rgray_d = (rbin_d >> 1) ^ rbin_d;
  wire         empty_d = rgray_d == rq2_q;

  assign wr_ready = wready_q;
  assign rd_valid = rvalid_q;
  assign rd_data  = mem[rbin_q[AW-1:0]];

  always_ff @(posedge wclk or negedge wrstn) begin
    if (!wrstn) begin
      wbin_q   <= '0;
      wgray_q  <= '0;
      wq1_q    <= '0;
      wq2_q    <= '0;
      wready_q <= 1'b0;
    end else begin
      wbin_q   <= wbin_d;
      wgray_q  <= wgray_d;
      wq1_q    <= rgray_q;
      wq2_q    <= wq1_q;
      wready_q <= ~full_d;
    end
  end

  always_ff @(posedge wclk) begin
    if (wpush) begin
      mem[wbin_q[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge rclk or negedge rrstn) begin
    if (!rrstn) begin
      rbin_q   <= '0;
      rgray_q  <= '0;
      rq1_q    <= '0;
      rq2_q    <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rbin_q   <= rbin_d;
      rgray_q  <= rgray_d;
      rq1_q    <= wgray_q;
      rq2_q    <= rq1_q;
      rvalid_q <= ~empty_d;
    end
  end
endmodule

// Function
// - lamp follows speed or activity per mode
// - strap pin input with pull during reset
// - receive nibbles change only on link clock
// - receive data valid only while valid strobe
// - transmit nibbles taken only while enable high
// - two-bit lamp mode is software programmable
// - lamp pin level latched as speed select
module pslq_top #(
  parameter int BLINK_CYC = pslq_pkg::BLINK_CYC
) (
  input  wire logic                          mclk,
  input  wire logic                          rstn,
  input  wire logic                          lnk_clk,
  input  wire logic                          rx_in_valid,
  input  wire logic [pslq_pkg::NIB_W-1:0]    rx_in_data,
  output logic                               rx_in_ready,
  output logic                               tx_out_valid,
  output logic [pslq_pkg::NIB_W-1:0]         tx_out_data,
  input  wire logic                          tx_out_ready,
  output logic [pslq_pkg::NIB_W-1:0]         rxd,
  output logic                               rx_dv,
  input  wire logic [pslq_pkg::NIB_W-1:0]    txd,
  input  wire logic                          tx_en,
  output logic                               tx_drop,
  input  wire logic                          speed_100,
  input  wire logic [pslq_pkg::LAMP_MODE_W-1:0] lamp_mode,
  input  wire logic                          lamp_i,
  output logic                               lamp_o,
  output logic                               lamp_oe,
  output logic                               lamp_pull_en,
  output logic                               strap_speed
);
  localparam int NW = pslq_pkg::NIB_W;

  pslq_pkg::pslq_strap_type st_q;
  logic          lrst1_q, lrst2_q, rx_dv_q, tx_en_q, tx_drop_q, act_l_q;
  logic          act_s1_q, act_s2_q, act_seen_q, lamp_q, lamp_oe_q, pull_q;
  logic          lamp_s1_q, lamp_s2_q, strap_speed_q, tx_v_q;
  logic          rf_rd_valid, tf_wr_ready, tf_rd_valid;
  logic [NW-1:0] rxd_q, txd_q, tx_d_q, rf_rd_data, tf_rd_data;
  logic [31:0]   blink_cnt_q;
  logic [1:0]    settle_q;

  wire lrstn    = lrst2_q;
  wire run      = st_q == pslq_pkg::ST_RUN;
  wire settled  = settle_q == pslq_pkg::STRAP_SETTLE;
  wire wrap     = blink_cnt_q == '0;
  wire tf_rd_rdy = ~tx_v_q | tx_out_ready;
  wire tf_take  = tf_rd_valid & tf_rd_rdy;
  wire is_speed = lamp_mode == pslq_pkg::LAMP_SPEED;
  wire is_act   = lamp_mode == pslq_pkg::LAMP_ACT;
  wire act_seen_d = act_s2_q | (act_seen_q & ~wrap);
  wire act_lamp = act_seen_q ? ~lamp_q : pslq_pkg::LAMP_OFF;
  wire spd_lamp = speed_100 ? pslq_pkg::LAMP_ON : pslq_pkg::LAMP_OFF;
  wire lamp_d   = !run ? pslq_pkg::LAMP_OFF :
                  is_speed ? spd_lamp :
                  is_act ? (wrap ? act_lamp : lamp_q) : pslq_pkg::LAMP_OFF;

  assign rxd          = rxd_q;
  assign rx_dv        = rx_dv_q;
  assign tx_drop      = tx_drop_q;
  assign lamp_o       = lamp_q;
  assign lamp_oe      = lamp_oe_q;
  assign lamp_pull_en = pull_q;
  assign strap_speed  = strap_speed_q;
  assign tx_out_valid = tx_v_q;
  assign tx_out_data  = tx_d_q;

  pslq_afifo #(.W(NW), .DEPTH(pslq_pkg::FIFO_DEPTH)) u_rx_fifo (
    .wclk(mclk), .wrstn(rstn), .wr_valid(rx_in_valid), .wr_data(rx_in_data), .wr_ready(rx_in_ready),
    .rclk(lnk_clk), .rrstn(lrstn), .rd_valid(rf_rd_valid), .rd_data(rf_rd_data), .rd_ready(lrstn));

  pslq_afifo #(.W(NW), .DEPTH(pslq_pkg::FIFO_DEPTH)) u_tx_fifo (
    .wclk(lnk_clk), .wrstn(lrstn), .wr_valid(tx_en_q), .wr_data(txd_q), .wr_ready(tf_wr_ready),
    .rclk(mclk), .rrstn(rstn), .rd_valid(tf_rd_valid), .rd_data(tf_rd_data), .rd_ready(tf_rd_rdy));

  // link domain reset: asynchronous assert, synchronous release
  always_ff @(posedge lnk_clk or negedge rstn) begin
    if (!rstn) begin
      lrst1_q <= 1'b0;
      lrst2_q <= 1'b0;
    end else begin
      lrst1_q <= 1'b1;
      lrst2_q <= lrst1_q;
    end
  end

  always_ff @(posedge lnk_clk or negedge lrstn) begin
    if (!lrstn) begin
      rxd_q     <= '0;
      rx_dv_q   <= 1'b0;
      txd_q     <= '0;
      tx_en_q   <= 1'b0;
      tx_drop_q <= 1'b0;
      act_l_q   <= 1'b0;
    end else begin
      rx_dv_q   <= rf_rd_valid;
      rxd_q     <= rf_rd_valid ? rf_rd_data : '0;
      txd_q     <= txd;
      tx_en_q   <= tx_en;
      tx_drop_q <= tx_en_q & ~tf_wr_ready;
      act_l_q   <= rx_dv_q | tx_en_q;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q          <= pslq_pkg::ST_STRAP;
      lamp_s1_q     <= 1'b0;
      lamp_s2_q     <= 1'b0;
      settle_q      <= '0;
      strap_speed_q <= 1'b0;
      lamp_oe_q     <= 1'b0;
      pull_q        <= 1'b1;
    end else begin
      lamp_s1_q <= lamp_i;
      lamp_s2_q <= lamp_s1_q;
      case (st_q)
        pslq_pkg::ST_STRAP: begin
          settle_q <= settle_q + 2'h1;
          if (settled) begin
            strap_speed_q <= lamp_s2_q;
            lamp_oe_q     <= 1'b1;
            pull_q        <= 1'b0;
            st_q          <= pslq_pkg::ST_RUN;
          end
        end
        default: begin
          st_q <= pslq_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      act_s1_q    <= 1'b0;
      act_s2_q    <= 1'b0;
      act_seen_q  <= 1'b0;
      blink_cnt_q <= '0;
      lamp_q      <= pslq_pkg::LAMP_OFF;
    end else begin
      act_s1_q    <= act_l_q;
      act_s2_q    <= act_s1_q;
      act_seen_q  <= act_seen_d;
      blink_cnt_q <= wrap ? 32'(BLINK_CYC - 1) : blink_cnt_q - 32'h1;
      lamp_q      <= lamp_d;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_v_q <= 1'b0;
      tx_d_q <= '0;
    end else if (tf_take) begin
      tx_v_q <= 1'b1;
      tx_d_q <= tf_rd_data;
    end else if (tx_out_ready) begin
      tx_v_q <= 1'b0;
    end
  end

  property p_speed_lamp;
    @(posedge mclk) disable iff (!rstn)
      run && is_speed |=> lamp_q == ($past(speed_100) ? pslq_pkg::LAMP_ON : pslq_pkg::LAMP_OFF);
  endproperty
  a_speed_lamp: assert property (p_speed_lamp) else $error("lamp does not follow speed");
  property p_strap_input;
    @(posedge mclk) disable iff (!rstn)
      !run |-> !lamp_oe_q && pull_q;
  endproperty
  a_strap_input: assert property (p_strap_input) else $error("strap pin driven before release");
  property p_rxd_step;
    @(posedge lnk_clk) disable iff (!lrstn)
      $changed(rxd_q) |-> rx_dv_q || $past(rx_dv_q);
  endproperty
  a_rxd_step: assert property (p_rxd_step) else $error("rxd moved outside a nibble");
  property p_rx_valid;
    @(posedge lnk_clk) disable iff (!lrstn)
      rx_dv_q |-> $past(rf_rd_valid) && rxd_q == $past(rf_rd_data);
  endproperty
  a_rx_valid: assert property (p_rx_valid) else $error("rx_dv without fifo data");
  sequence s_tx_idle;
    !tx_en ##1 1'b1;
  endsequence
  property p_tx_qualify;
    @(posedge lnk_clk) disable iff (!lrstn)
      s_tx_idle |-> !tx_en_q;
  endproperty
  a_tx_qualify: assert property (p_tx_qualify) else $error("tx nibble taken without enable");
  property p_blink_phase;
    @(posedge mclk) disable iff (!rstn)
      run && is_act && $past(is_act) && $changed(lamp_q) |-> $past(wrap);
  endproperty
  a_blink_phase: assert property (p_blink_phase) else $error("lamp toggled mid phase");
  property p_reserved_off;
    @(posedge mclk) disable iff (!rstn)
      run && lamp_mode[1] |=> lamp_q == pslq_pkg::LAMP_OFF;
  endproperty
  a_reserved_off: assert property (p_reserved_off) else $error("reserved mode lamp not off");
  sequence s_release;
    !run ##1 run;
  endsequence
  property p_strap_latch;
    @(posedge mclk) disable iff (!rstn)
      s_release |-> strap_speed_q == $past(lamp_s2_q) && lamp_oe_q;
  endproperty
  a_strap_latch: assert property (p_strap_latch) else $error("strap speed not latched");
endmodule

// [verif/pslq_mac_model.sv]
// mac side model: drives the mii transmit lanes on the device's link clock
// assumes the bench calls send and idle; receive side is watched by the bench
module pslq_mac_model (
  input  wire logic       lnk_clk,
  output logic [3:0]      txd,
  output logic            tx_en
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    txd   = 4'h0;
    tx_en = 1'b0;
  end
  // one nibble per link cycle, changed just after the edge
  task automatic send(input logic [3:0] nib, input logic en);
    @(posedge lnk_clk);
    #1;
    tx_en = en;
    txd   = nib;
  endtask
  // idle lanes keep moving so stale data never looks valid
  task automatic idle();
    @(posedge lnk_clk);
    #1;
    tx_en = 1'b0;
    txd   = ~txd;
  endtask
endmodule

// [verif/test_pslq_top.sv]
// self-checking bench for the lamp, strap and mii nibble qualify block
// assumes pslq_mac_model at the mii side; the lamp pin wire is resolved here
module test_pslq_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, rstn, lnk_clk, rx_in_valid, tx_out_ready, speed_100, strap_lvl;
  logic [3:0] rx_in_data, txd, rxd, tx_out_data;
  logic       rx_in_ready, tx_out_valid, rx_dv, tx_en, tx_drop, lamp_o, lamp_oe, lamp_pull_en, strap_speed;
  logic [1:0] lamp_mode;
  logic       stall, sawfull, last;
  logic [3:0] rxq[$], txq[$];
  int         fails, n_compared, drops, chg, gap, mingap;
  int         seed = 66;
  wire        lamp_i = lamp_oe ? lamp_o : strap_lvl;

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    lnk_clk = 1'b0;
    #7;
    forever #32 lnk_clk = ~lnk_clk;
  end

  pslq_top #(.BLINK_CYC(16)) DUT (
    .mclk(mclk), .rstn(rstn), .lnk_clk(lnk_clk), .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data),
    .rx_in_ready(rx_in_ready), .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
    .tx_out_ready(tx_out_ready), .rxd(rxd), .rx_dv(rx_dv), .txd(txd), .tx_en(tx_en), .tx_drop(tx_drop),
    .speed_100(speed_100), .lamp_mode(lamp_mode), .lamp_i(lamp_i), .lamp_o(lamp_o), .lamp_oe(lamp_oe),
    .lamp_pull_en(lamp_pull_en), .strap_speed(strap_speed));
  pslq_mac_model mac (.lnk_clk(lnk_clk), .txd(txd), .tx_en(tx_en));

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic rx_send(input logic [3:0] nib);
    rx_in_valid = 1'b1;
    rx_in_data  = nib;
    // ready is a flop: the value seen just after an edge is the one taken at the next edge
    while (rx_in_ready !== 1'b1) begin
      sawfull = 1'b1;
      clk(1);
    end
    @(posedge mclk);
    rxq.push_back(nib);
    #1;
  endtask
  task automatic tx_burst(input int n, input bit gaps);
    logic [3:0] nib;
    logic       en;
    for (int i = 0; i < n; i++) begin
      nib = 4'($random(seed));
      en  = !gaps || nib[0];
      mac.send(nib, en);
      if (en) txq.push_back(nib);
    end
    mac.idle();
  endtask

  // result watchers take the oldest note
  always @(negedge lnk_clk) begin
    if (rx_dv === 1'b1) check(rxd, rxq.size() ? rxq.pop_front() : ~rxd);
    if (tx_drop === 1'b1) drops++;
  end
  always @(negedge mclk)
    if (tx_out_valid === 1'b1 && tx_out_ready === 1'b1) check(tx_out_data, txq.size() ? txq.pop_front() : ~tx_out_data);
  always @(posedge mclk) begin
    #1 tx_out_ready = !stall && ($random(seed) & 1) != 0;
  end

  initial begin
    #100000;
    fails++;
    final_report();
  end

  initial begin
    rstn = 1'b0; rx_in_valid = 1'b0; rx_in_data = 4'h0; tx_out_ready = 1'b0; speed_100 = 1'b0;
    lamp_mode = 2'h0; strap_lvl = 1'b0; stall = 1'b0; sawfull = 1'b0; fails = 0; n_compared = 0; drops = 0;
    for (int s = 0; s < 2; s++) begin
      rstn = 1'b0;
      strap_lvl = s[0];
      clk(5);
      check({lamp_pull_en, lamp_oe}, 8'h2);
      rstn = 1'b1;
      clk(6);
      check({lamp_pull_en, lamp_oe, strap_speed}, {6'h1, s[0]});
      $display("test strap %0d done", s);
    end
    for (int m = 0; m < 4; m++) begin
      lamp_mode = 2'(m);
      for (int sp = 0; sp < 2; sp++) begin
        speed_100 = sp[0];
        clk(40);
        check(lamp_o, (m == 0) ? !sp[0] : 1'b1);
      end
    end
    $display("test lamp modes done");
    lamp_mode = 2'h1;
    chg = 0; gap = 0; mingap = 99; last = lamp_o;
    fork
      tx_burst(30, 1'b0);
      repeat (160) begin
        clk(1);
        gap++;
        if (lamp_o !== last) begin
          if (chg > 0 && gap < mingap) mingap = gap;
          chg++;
          gap = 0;
        end
        last = lamp_o;
      end
    join
    check({chg >= 8, mingap >= 16}, 8'h3);
    clk(100);
    check(lamp_o, 1'b1);
    $display("test blink done");
    tx_burst(24, 1'b1);
    clk(100);
    $display("test tx enable done");
    for (int i = 0; i < 20; i++) rx_send(4'($random(seed)));
    rx_in_valid = 1'b0;
    clk(400);
    check({sawfull, 7'(rxq.size())}, 8'h80);
    $display("test rx fill done");
    stall = 1'b1;
    drops = 0;
    tx_burst(24, 1'b0);
    clk(20);
    repeat (drops) void'(txq.pop_back());
    check(drops > 0, 1'b1);
    stall = 1'b0;
    clk(200);
    check(8'(txq.size()), 8'h0);
    $display("test tx fill done");
    final_report();
  end
endmodule
